//--- rtl/msp_pkg.sv
/*
 Constants, field layouts and carrier types of the multimode clocked serial port.
 Assumes a single 25 MHz clock domain and a plain strobe register port.
*/
// Overview of operation
// [RL1] Enable and two mode bits select mode.
// [RL2] Disabled port: no shift, counter cleared, flag held.
// [RL3] Match bit compares slave address with shift data.
// [RL4] Wakeup: done only on matching address after release.
// [RL5] Wakeup setting never releases an active busy.
// [RL6] Three-wire: mode_bit_lo picks MSB or LSB first.
// [RL7] Two-wire modes: MSB first, open-drain, pin selectable.
// [RL8] Clock select: external, timer, divide 16/64, divide 8.
// [RL9] Clock pin state follows enable and clock select.
// [RL10] Software stops: irq enable, enable, then flag.
// [RL11] Bus control written only bit by bit; resets zero.
// [RL12] Three/two-wire software uses only trigger bits.
// [RL13] Busy follows acknowledge; stops on falling edge.
// [RL14] Ack detected on rising edge; cleared at start.
// [RL15] Auto acknowledge on ninth clock or next clock.
// [RL16] Ack trigger drives next clock, then self-clears.
// [RL17] Command flag sets on command, clears on start/release/halt.
// [RL18] Release flag clears on start, halt, address mismatch.
// [RL19] Release trigger sets latch; command trigger clears it.
// [RL20] Shift data write starts an eight-bit transfer.
// [RL21] Software accesses shift data only while clock high.
// [RL22] Receivers on shared line load all ones.
// [RL23] Shift on falling edge, capture on rising edge.
// [RL24] Addressed mode sets latch after eighth clock.

package msp_pkg;

   // ==========================================================
   // Register map
   localparam logic [2:0] REG_MODE   = 3'h0;
   localparam logic [2:0] REG_BUSCTL = 3'h1;
   localparam logic [2:0] REG_BUSBIT = 3'h2;
   localparam logic [2:0] REG_SHIFT  = 3'h3;
   localparam logic [2:0] REG_SLAVE  = 3'h4;
   localparam logic [2:0] REG_STATUS = 3'h5;

   // ==========================================================
   // Bit positions in the bus control register, and of the value bit in a bit write
   localparam logic [2:0] BC_BUSY_EN  = 3'h7;
   localparam logic [2:0] BC_ACK_AUTO = 3'h5;
   localparam logic [2:0] BC_ACK_TRIG = 3'h4;
   localparam logic [2:0] BC_CMD_TRIG = 3'h1;
   localparam logic [2:0] BC_REL_TRIG = 3'h0;
   localparam int         BIT_VAL_POS = 3;

   // Status register bit positions.
   localparam int ST_DONE   = 0;
   localparam int ST_BUSY   = 1;
   localparam int ST_ACTIVE = 2;

   // ==========================================================
   // Reset values and counts
   localparam logic [7:0] MODE_RESET    = 8'h00;
   localparam logic [7:0] BUSCTL_RESET  = 8'h00;
   localparam logic [7:0] SLAVE_RESET   = 8'h00;
   localparam logic [3:0] LAST_BIT      = 4'h7;
   localparam logic [1:0] CS_EXTERNAL   = 2'h0;
   localparam logic [1:0] CS_TIMER      = 2'h1;
   localparam logic [1:0] CS_FAST       = 2'h3;
   localparam int         DIV_FAST      = 8;
   localparam int         DIV_MID       = 16;
   localparam int         DIV_SLOW      = 64;
   localparam logic [5:0] HALF_FAST     = 6'(DIV_FAST / 2 - 1);
   localparam logic [5:0] HALF_MID      = 6'(DIV_MID / 2 - 1);
   localparam logic [5:0] HALF_SLOW     = 6'(DIV_SLOW / 2 - 1);

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic       enable;
      logic       match;
      logic       wakeup;
      logic       pin_sel;
      logic       mode_hi;
      logic       mode_lo;
      logic [1:0] clk_sel;
   } msp_mode_t;

   typedef struct packed {
      logic busy_en;
      logic ack_det;
      logic ack_auto;
      logic ack_trig;
      logic cmd_det;
      logic rel_det;
      logic cmd_trig;
      logic rel_trig;
   } msp_busctl_t;

   typedef enum {MSP_HALT, MSP_THREE, MSP_ADDR, MSP_TWO} msp_opmode_t;

endpackage : msp_pkg

//--- rtl/msp_serial_port.sv
/*
 Multimode clocked serial port: halt, three-wire, two-wire and addressed bus modes.
 Assumes pins and the timer output arrive asynchronously and the pad logic resolves
 open-drain lines from the output enables.
*/
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps

module msp_serial_port (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data,
   input  wire logic       sck_i,
   output logic            sck_o,
   output logic            sck_oe,
   input  wire logic       line_a_i,
   output logic            line_a_o,
   output logic            line_a_oe,
   input  wire logic       line_b_i,
   output logic            line_b_o,
   output logic            line_b_oe,
   input  wire logic       timer_output,
   output logic            transfer_done_flag
);

   // ==========================================================
   // Input synchronisers
   // Three stages; a change is taken once the last two agree, which also rejects
   // single-cycle glitches on the slow serial clock.
   logic [3:0] raw_in;
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] s3_q;
   logic [3:0] filt_q;

   assign raw_in = {timer_output, line_b_i, line_a_i, sck_i};

   for (genvar gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            s1_q[gi]   <= 1'b1;
            s2_q[gi]   <= 1'b1;
            s3_q[gi]   <= 1'b1;
            filt_q[gi] <= 1'b1;
         end else begin
            s1_q[gi] <= raw_in[gi];
            s2_q[gi] <= s1_q[gi];
            s3_q[gi] <= s2_q[gi];
            if (s2_q[gi] == s3_q[gi]) begin
               filt_q[gi] <= s3_q[gi];
            end
         end
      end
   end

   // ==========================================================
   // Registers and decode
   msp_pkg::msp_mode_t   mode_q;
   msp_pkg::msp_busctl_t bc_q;
   msp_pkg::msp_opmode_t opmode;
   logic [7:0] sh_q;
   logic [7:0] sva_q;
   logic [7:0] sh_next;
   logic [3:0] cnt_q;
   logic [5:0] div_q;
   logic [5:0] half;
   logic       xfer_q;
   logic       so_q;
   logic       match_q;
   logic       busy_q;
   logic       ack_pend_q;
   logic       ack_drive_q;
   logic       post_rel_q;
   logic       sclk_int_q;
   logic       sclk_prev_q;
   logic       lvl_prev_q;
   logic       rise_q;
   logic       sclk_cur;
   logic       fall;
   logic       rise;
   logic       in_bit;
   logic       bus_lvl;
   logic       wr_mode;
   logic       wr_bit;
   logic       wr_shift;
   logic       start;
   logic       done_evt;
   logic       match_next;
   logic       wake_ok;
   logic       rel_evt;
   logic       cmd_evt;
   logic       bus_low;

   function automatic logic bit_hit(input logic [7:0] d, input logic [2:0] pos);
      bit_hit = (d[2:0] == pos) && d[msp_pkg::BIT_VAL_POS];
   endfunction : bit_hit

   assign wr_mode  = wr_en && (addr == msp_pkg::REG_MODE);
   assign wr_bit   = wr_en && (addr == msp_pkg::REG_BUSBIT);
   assign wr_shift = wr_en && (addr == msp_pkg::REG_SHIFT);
   assign start    = wr_shift && mode_q.enable;

   always_comb begin
      case ({mode_q.enable, mode_q.mode_hi, mode_q.mode_lo})
         3'b100, 3'b101: opmode = msp_pkg::MSP_THREE; // RL1
         3'b110:         opmode = msp_pkg::MSP_ADDR;  // RL1
         3'b111:         opmode = msp_pkg::MSP_TWO;   // RL1
         default:        opmode = msp_pkg::MSP_HALT;  // RL1
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= msp_pkg::MODE_RESET;
      end else if (wr_mode) begin
         mode_q       <= wr_data;
         mode_q.match <= 1'b0; // RL3
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sva_q <= msp_pkg::SLAVE_RESET;
      end else if (wr_en && (addr == msp_pkg::REG_SLAVE)) begin
         sva_q <= wr_data;
      end
   end

   // ==========================================================
   // Serial clock selection and generation
   always_comb begin
      if (mode_q.clk_sel == msp_pkg::CS_FAST) begin
         half = msp_pkg::HALF_FAST; // RL8
      end else if (opmode == msp_pkg::MSP_TWO) begin
         half = msp_pkg::HALF_SLOW; // RL8
      end else begin
         half = msp_pkg::HALF_MID; // RL8
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_q      <= 6'h00;
         sclk_int_q <= 1'b1;
      end else if (xfer_q || ack_pend_q || bc_q.ack_trig || !sclk_int_q) begin
         if (div_q >= half) begin
            div_q      <= 6'h00;
            sclk_int_q <= ~sclk_int_q;
         end else begin
            div_q <= div_q + 6'h01;
         end
      end else begin
         div_q      <= 6'h00;
         sclk_int_q <= 1'b1;
      end
   end

   always_comb begin
      case (mode_q.clk_sel)
         msp_pkg::CS_EXTERNAL: sclk_cur = filt_q[0]; // RL8
         msp_pkg::CS_TIMER:    sclk_cur = filt_q[3]; // RL8
         default:              sclk_cur = sclk_int_q;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_prev_q <= 1'b1;
         lvl_prev_q  <= 1'b1;
         rise_q      <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_cur;
         lvl_prev_q  <= bus_lvl;
         rise_q      <= !sclk_prev_q && sclk_cur;
      end
   end

   // The rising edge is used one clock late because the data pin passes the synchroniser
   // while the internal clock does not; at divide 8 the bit would otherwise be stale.
   assign fall    = sclk_prev_q && !sclk_cur;
   assign rise    = rise_q;
   assign bus_lvl = mode_q.pin_sel ? filt_q[2] : filt_q[1];
   assign in_bit  = (opmode == msp_pkg::MSP_THREE) ? filt_q[2] : bus_lvl; // RL6 RL7

   // ==========================================================
   // Shift engine
   // Only three-wire mode may run LSB first; the shared-line modes are MSB first.
   always_comb begin
      if ((opmode == msp_pkg::MSP_THREE) && mode_q.mode_lo) begin
         sh_next = {in_bit, sh_q[7:1]}; // RL6
      end else begin
         sh_next = {sh_q[6:0], in_bit}; // RL7
      end
   end

   assign done_evt   = rise && xfer_q && (cnt_q == msp_pkg::LAST_BIT) && mode_q.enable;
   assign match_next = (sva_q == sh_next);
   assign wake_ok    = !(mode_q.wakeup && (opmode == msp_pkg::MSP_ADDR))
                       || (post_rel_q && match_next); // RL4

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sh_q <= 8'h00;
      end else if (wr_shift) begin
         sh_q <= wr_data; // RL20
      end else if (rise && xfer_q && mode_q.enable) begin
         sh_q <= sh_next; // RL23
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         xfer_q <= 1'b0;
         cnt_q  <= 4'h0;
      end else if (!mode_q.enable) begin
         xfer_q <= 1'b0; // RL2
         cnt_q  <= 4'h0; // RL2
      end else if (start || (rel_evt && mode_q.wakeup)) begin
         xfer_q <= 1'b1; // RL20
         cnt_q  <= 4'h0;
      end else if (rise && xfer_q) begin
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == msp_pkg::LAST_BIT) begin
            xfer_q <= 1'b0; // RL20
            cnt_q  <= 4'h0;
         end
      end
   end

   // The output latch is the one place where triggers, shifting and the
   // post-byte release meet; triggers win because software drives them idle.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         so_q <= 1'b1;
      end else if (bc_q.rel_trig) begin
         so_q <= 1'b1; // RL19
      end else if (bc_q.cmd_trig) begin
         so_q <= 1'b0; // RL19
      end else if (done_evt && (opmode == msp_pkg::MSP_ADDR)) begin
         so_q <= 1'b1; // RL24
      end else if (fall && xfer_q && mode_q.enable) begin
         so_q <= ((opmode == msp_pkg::MSP_THREE) && mode_q.mode_lo) ? sh_q[0] : sh_q[7]; // RL23
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         match_q <= 1'b0;
      end else begin
         match_q <= (sva_q == sh_q); // RL3
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         transfer_done_flag <= 1'b0;
      end else if (done_evt && wake_ok) begin
         transfer_done_flag <= 1'b1; // RL4 RL23
      end else if (wr_en && (addr == msp_pkg::REG_STATUS) && wr_data[msp_pkg::ST_DONE]) begin
         transfer_done_flag <= 1'b0;
      end
   end

   // ==========================================================
   // Addressed bus signalling
   // Release and command are data edges while the serial clock stays high.
   assign rel_evt = (opmode == msp_pkg::MSP_ADDR) && sclk_cur && sclk_prev_q
                    && bus_lvl && !lvl_prev_q;
   assign cmd_evt = (opmode == msp_pkg::MSP_ADDR) && sclk_cur && sclk_prev_q
                    && !bus_lvl && lvl_prev_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         post_rel_q <= 1'b0;
      end else if (rel_evt) begin
         post_rel_q <= 1'b1;
      end else if (done_evt || !mode_q.enable) begin
         post_rel_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_pend_q <= 1'b0;
      end else if (done_evt && (opmode == msp_pkg::MSP_ADDR)) begin
         ack_pend_q <= 1'b1; // RL15
      end else if (rise || !mode_q.enable) begin
         ack_pend_q <= 1'b0;
      end
   end

   // Busy is released by clearing busy enable at a falling edge or by leaving addressed mode, never by wakeup.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_drive_q <= 1'b0;
         busy_q      <= 1'b0;
      end else if (opmode != msp_pkg::MSP_ADDR) begin
         ack_drive_q <= 1'b0;
         busy_q      <= 1'b0;
      end else if (fall) begin
         ack_drive_q <= (ack_pend_q && bc_q.ack_auto) || bc_q.ack_trig; // RL15 RL16
         if (ack_drive_q && bc_q.busy_en) begin
            busy_q <= 1'b1; // RL13
         end else if (!bc_q.busy_en) begin
            busy_q <= 1'b0; // RL13 RL5
         end
      end
   end

   // ==========================================================
   // Bus control register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bc_q <= msp_pkg::BUSCTL_RESET; // RL11
      end else begin
         if (wr_bit && (wr_data[2:0] == msp_pkg::BC_BUSY_EN)) begin
            bc_q.busy_en <= wr_data[msp_pkg::BIT_VAL_POS]; // RL11
         end
         if (wr_bit && (wr_data[2:0] == msp_pkg::BC_ACK_AUTO)) begin
            bc_q.ack_auto <= wr_data[msp_pkg::BIT_VAL_POS];
         end
         if (bit_hit(wr_data, msp_pkg::BC_ACK_TRIG) && wr_bit) begin
            bc_q.ack_trig <= 1'b1; // RL16
         end else if (fall || !mode_q.enable) begin
            bc_q.ack_trig <= 1'b0; // RL16
         end
         bc_q.rel_trig <= wr_bit && bit_hit(wr_data, msp_pkg::BC_REL_TRIG); // RL19
         bc_q.cmd_trig <= wr_bit && bit_hit(wr_data, msp_pkg::BC_CMD_TRIG); // RL19
         if (rise && ack_pend_q && !bus_lvl) begin
            bc_q.ack_det <= 1'b1; // RL14
         end else if (start) begin
            bc_q.ack_det <= 1'b0; // RL14
         end
         if (cmd_evt) begin
            bc_q.cmd_det <= 1'b1; // RL17
         end else if (start || rel_evt || !mode_q.enable) begin
            bc_q.cmd_det <= 1'b0; // RL17
         end
         if (rel_evt) begin
            bc_q.rel_det <= 1'b1; // RL18
         end else if (start || !mode_q.enable || (done_evt && post_rel_q && !match_next)) begin
            bc_q.rel_det <= 1'b0; // RL18
         end
      end
   end

   // ==========================================================
   // Pins and read port
   assign bus_low = (!so_q && !(mode_q.wakeup && (opmode == msp_pkg::MSP_ADDR)))
                    || ack_drive_q || busy_q; // RL4

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         line_a_o  <= 1'b1;
         line_a_oe <= 1'b0;
         line_b_o  <= 1'b1;
         line_b_oe <= 1'b0;
      end else begin
         case (opmode)
            msp_pkg::MSP_THREE: begin
               line_a_o  <= so_q; // RL6
               line_a_oe <= 1'b1;
               line_b_o  <= 1'b1;
               line_b_oe <= 1'b0;
            end
            msp_pkg::MSP_ADDR, msp_pkg::MSP_TWO: begin
               line_a_o  <= 1'b0; // RL7
               line_a_oe <= bus_low && !mode_q.pin_sel;
               line_b_o  <= 1'b0;
               line_b_oe <= bus_low && mode_q.pin_sel;
            end
            default: begin
               line_a_o  <= 1'b1; // RL2
               line_a_oe <= 1'b0;
               line_b_o  <= 1'b1;
               line_b_oe <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sck_o  <= 1'b1;
         sck_oe <= 1'b0;
      end else if (mode_q.clk_sel == msp_pkg::CS_EXTERNAL) begin
         sck_o  <= 1'b1; // RL9
         sck_oe <= 1'b0;
      end else begin
         sck_o  <= mode_q.enable ? sclk_cur : 1'b1; // RL9
         sck_oe <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            msp_pkg::REG_MODE:   rd_data <= {mode_q.enable, match_q, mode_q[5:0]}; // RL3
            msp_pkg::REG_BUSCTL: rd_data <= bc_q;
            msp_pkg::REG_SHIFT:  rd_data <= sh_q;
            msp_pkg::REG_SLAVE:  rd_data <= sva_q;
            msp_pkg::REG_STATUS: rd_data <= {5'h00, xfer_q, busy_q, transfer_done_flag};
            default:             rd_data <= 8'h00;
         endcase
      end else begin
         rd_data <= 8'h00;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence seq_rel_write;
      wr_bit && (wr_data[3:0] == 4'h8);
   endsequence

   sequence seq_cmd_write;
      wr_bit && (wr_data[3:0] == 4'h9);
   endsequence

   AST_HALT_IDLE: assert property (!mode_q.enable |=> (cnt_q == 4'h0) && !xfer_q) // RL2
      else $error("Halted port kept counting.");
   AST_DONE_SET: assert property (done_evt && wake_ok |=> transfer_done_flag) // RL23
      else $error("Completed transfer did not raise the done flag.");
   AST_WAKE_BLOCK: assert property (done_evt && !wake_ok && !transfer_done_flag
                                    && !(wr_en && (addr == msp_pkg::REG_STATUS))
                                    |=> !transfer_done_flag) // RL4
      else $error("Done flag set without address match in wakeup.");
   AST_REL_TRIG: assert property (seq_rel_write |-> ##2 so_q ##1 !bc_q.rel_trig) // RL19
      else $error("Release trigger did not set the output latch.");
   AST_CMD_TRIG: assert property (seq_cmd_write |-> ##2 !so_q) // RL19
      else $error("Command trigger did not clear the output latch.");
   AST_CNT_RANGE: assert property (cnt_q <= msp_pkg::LAST_BIT) // RL20
      else $error("Bit counter passed eight bits.");
   AST_START: assert property (start |=> xfer_q && (cnt_q == 4'h0)) // RL20
      else $error("Shift write did not start a transfer.");
   AST_SCK_HALT: assert property (!mode_q.enable && (mode_q.clk_sel != 2'h0)
                                  |=> sck_oe && sck_o) // RL9
      else $error("Clock pin not driven high while halted.");
   AST_THREE_PINS: assert property (opmode == msp_pkg::MSP_THREE
                                    |=> line_a_oe && !line_b_oe) // RL6
      else $error("Three-wire pin directions wrong.");
   AST_BYTE_BUSCTL: assert property (wr_en && (addr == msp_pkg::REG_BUSCTL)
                                     |=> $stable(bc_q.busy_en) && $stable(bc_q.ack_auto)) // RL11
      else $error("Byte write changed bus control bits.");
   AST_BUSY_HOLD: assert property (busy_q && bc_q.busy_en && (opmode == msp_pkg::MSP_ADDR)
                                   |=> busy_q) // RL5
      else $error("Busy released while busy enable stood.");

endmodule : msp_serial_port

//--- tb/msp_far_end.sv
/*
 Far-side three-wire serial device: shifts a byte in and out, MSB first.
 Assumes it sees the resolved clock pin and the data out pin of the port.
*/
`timescale 1ns/10ps

module msp_far_end (
   input  wire logic       sck,
   input  wire logic       din,
   input  wire logic [7:0] load,
   input  wire logic       load_en,
   output logic            dout,
   output logic [7:0]      got
);
   logic [7:0] tx_q;
   int         n;

   initial begin
      dout = 1'b1;
      got  = 8'h00;
      tx_q = 8'h00;
      n    = 0;
   end

   // Loads a byte and presents its first bit before the first rising edge.
   always @(posedge load_en) begin
      tx_q = load;
      n    = 0;
      dout = load[7];
   end

   // Capture on rising edge; after the frame the line no longer holds its last bit.
   always @(posedge sck) begin
      got = {got[6:0], din};
      n   = n + 1;
      if (n == 8) begin
         #100 dout = ~dout;
      end
   end

   always @(negedge sck) begin
      if (n > 0 && n < 8) begin
         tx_q = tx_q << 1;
         dout = tx_q[7];
      end
   end
endmodule : msp_far_end

//--- tb/tb_top.sv
/*
 Self-checking bench of the serial port: register access, modes and transfers.
 Assumes the far-side model on the three-wire pins and a pull-up on released lines.
*/
`timescale 1ns/10ps

module tb_top;
   logic       clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, far_go = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wr_data = 8'h00, rd_data, v, far_got, far_load = 8'h00;
   logic       sck_o, sck_oe, line_a_o, line_a_oe, line_b_o, line_b_oe;
   logic       transfer_done_flag, far_dout;
   int         fails = 0, n_checks = 0;
   wire        sck_w = sck_oe ? sck_o : 1'b1;
   wire        la_w  = line_a_oe ? line_a_o : 1'b1;
   wire        lb_w  = line_b_oe ? line_b_o : far_dout;

   always #20 clk = ~clk;

   msp_serial_port i_msp_serial_port (.clk, .reset_n, .addr, .wr_data, .wr_en, .rd_en,
      .rd_data, .sck_i(sck_w), .sck_o, .sck_oe, .line_a_i(la_w), .line_a_o, .line_a_oe,
      .line_b_i(lb_w), .line_b_o, .line_b_oe, .timer_output(1'b0), .transfer_done_flag);

   msp_far_end i_msp_far_end (.sck(sck_w), .din(la_w), .load(far_load), .load_en(far_go),
      .dout(far_dout), .got(far_got));

   // ==========================================================
   // Bus tasks
   task summarize;
      if (fails == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize

   task chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   task rdchk(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rd_data, e);
   endtask : rdchk

   function automatic logic [7:0] rev(input logic [7:0] d);
      for (int i = 0; i < 8; i++) rev[i] = d[7-i];
   endfunction : rev

   // The far side is loaded before the start write so its first bit is ready in time.
   task xfer(input logic [7:0] tx, input logic [7:0] rx);
      int cnt;
      far_load = rx;
      far_go   = 1'b1;
      #1 far_go = 1'b0;
      wr(msp_pkg::REG_SHIFT, tx);
      for (cnt = 0; cnt < 200 && transfer_done_flag !== 1'b1; cnt++) @(posedge clk);
      chk({7'h0, cnt >= 56 && cnt <= 72}, 8'h01);
      repeat (3) @(posedge clk);
   endtask : xfer

   // ==========================================================
   // Tests
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      chk({6'h0, sck_o, sck_oe}, 8'h02);
      rdchk(msp_pkg::REG_BUSCTL, 8'h00);
      wr(msp_pkg::REG_BUSCTL, 8'hFF);
      rdchk(msp_pkg::REG_BUSCTL, 8'h00);
      rdchk(3'h6, 8'h00);
      wr(msp_pkg::REG_SHIFT, 8'h5A);
      wr(msp_pkg::REG_MODE, 8'h43);
      rdchk(msp_pkg::REG_MODE, 8'h03);
      wr(msp_pkg::REG_SLAVE, 8'h5A);
      rdchk(msp_pkg::REG_MODE, 8'h43);
      repeat (2) @(posedge clk);
      chk({6'h0, sck_o, sck_oe}, 8'h03);
      wr(msp_pkg::REG_MODE, 8'h80);
      repeat (3) @(posedge clk);
      chk({7'h0, sck_oe}, 8'h00);
      wr(msp_pkg::REG_MODE, 8'h83);
      wr(msp_pkg::REG_BUSBIT, 8'h09);
      repeat (3) @(posedge clk);
      chk({6'h0, line_a_o, line_a_oe}, 8'h01);
      wr(msp_pkg::REG_BUSBIT, 8'h08);
      repeat (3) @(posedge clk);
      chk({6'h0, line_a_o, line_a_oe}, 8'h03);
      rdchk(msp_pkg::REG_BUSCTL, 8'h00);
      xfer(8'hA5, 8'h3C);
      chk(far_got, 8'hA5);
      rdchk(msp_pkg::REG_SHIFT, 8'h3C);
      rdchk(msp_pkg::REG_STATUS, 8'h01);
      wr(msp_pkg::REG_STATUS, 8'h01);
      rdchk(msp_pkg::REG_STATUS, 8'h00);
      wr(msp_pkg::REG_MODE, 8'h87);
      xfer(8'hC1, 8'h96);
      chk(far_got, rev(8'hC1));
      rdchk(msp_pkg::REG_SHIFT, rev(8'h96));
      wr(msp_pkg::REG_SHIFT, 8'hFF);
      repeat (20) @(posedge clk);
      rdchk(msp_pkg::REG_STATUS, 8'h05);
      wr(msp_pkg::REG_MODE, 8'h07);
      rdchk(msp_pkg::REG_STATUS, 8'h01);
      repeat (60) @(posedge clk);
      chk({7'h0, transfer_done_flag}, 8'h01);
      wr(msp_pkg::REG_STATUS, 8'h01);
      rdchk(msp_pkg::REG_STATUS, 8'h00);
      wr(msp_pkg::REG_BUSBIT, 8'h08);
      wr(msp_pkg::REG_MODE, 8'h8B);
      wr(msp_pkg::REG_BUSBIT, 8'h09);
      repeat (8) @(posedge clk);
      chk({6'h0, line_a_o, line_a_oe}, 8'h01);
      rdchk(msp_pkg::REG_BUSCTL, 8'h08);
      wr(msp_pkg::REG_BUSBIT, 8'h08);
      repeat (8) @(posedge clk);
      chk({6'h0, line_a_o, line_a_oe}, 8'h00);
      rdchk(msp_pkg::REG_BUSCTL, 8'h04);
      wr(msp_pkg::REG_MODE, 8'h0B);
      rdchk(msp_pkg::REG_BUSCTL, 8'h00);
      summarize;
   end

   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      summarize;
   end
endmodule : tb_top
